// file: hdl/pmc_consts.vh
// Offsets, field positions, reset values and timing counts of the power control register
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

`define PMC_ADDR_W          12
`define PMC_CTRL_OFFSET     12'h084
`define PMC_MODE_HI         31
`define PMC_MODE_LO         29
`define PMC_SLEEP_BIT       28
`define PMC_WAKE_EN_BIT     27
`define PMC_LED_OFF_BIT     26
`define PMC_TIME_OFF_BIT    25
`define PMC_TSU2_OFF_BIT    24
`define PMC_TSU1_OFF_BIT    23
`define PMC_TSU0_OFF_BIT    22
`define PMC_FABRIC_OFF_BIT  20
`define PMC_STS_B_BIT       17
`define PMC_STS_A_BIT       16
`define PMC_EN_B_BIT        15
`define PMC_EN_A_BIT        14
`define PMC_READY_BIT       0
`define PMC_MODE_FULL       3'h0
`define PMC_MODE_LIGHT      3'h1
`define PMC_MODE_MEDIUM     3'h2
`define PMC_MODE_DEEP       3'h3
`define PMC_CTRL_RESET      32'h00000000
`define PMC_UNUSED_DATA     32'h00000000
// Wake time in microseconds and the clock period in nanoseconds
`define PMC_WAKE_TIME_US    2000
`define PMC_CLK_PERIOD_NS   40
`define PMC_WAKE_CYCLES     ((`PMC_WAKE_TIME_US * 1000) / `PMC_CLK_PERIOD_NS)
`define PMC_STABLE_CYCLES   16

`endif

// file: hdl/pmc_guard_bit.v
// Clock disable bit that sets only after two consecutive writes of one

module pmc_guard_bit
(
    input  wire clk_in,
    input  wire rst_in,
    input  wire wr_in,
    input  wire data_in,
    output reg  bit_out
);

    reg armed;

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            armed   <= 1'b0;
            bit_out <= 1'b0;
        end
        else if (wr_in)
        begin
            if (!data_in)
            begin
                // A zero clears the bit and restarts the count
                armed   <= 1'b0;
                bit_out <= 1'b0;
            end
            else if (armed)
                bit_out <= 1'b1;
            else
                armed <= 1'b1;
        end
    end

endmodule // pmc_guard_bit

// file: hdl/pmc_power_ctrl.v
// Power management control register with sleep sequencing and clock gating

`include "pmc_consts.vh"

module pmc_power_ctrl
#(
    parameter WAKE_CYCLES   = `PMC_WAKE_CYCLES,
    parameter STABLE_CYCLES = `PMC_STABLE_CYCLES,
    parameter LED_COUNT     = 3
)
(
    input  wire                   clk_in,
    input  wire                   rst_in,
    input  wire [`PMC_ADDR_W-1:0] avs_address_in,
    input  wire                   avs_read_in,
    input  wire                   avs_write_in,
    input  wire [31:0]            avs_writedata_in,
    input  wire [3:0]             avs_byteenable_in,
    output reg  [31:0]            avs_readdata_out,
    output reg                    avs_waitrequest_out,
    input  wire                   port_a_event_in,
    input  wire                   port_b_event_in,
    input  wire                   manual_wake_in,
    input  wire                   pll_locked_in,
    input  wire [LED_COUNT-1:0]   led_value_in,
    input  wire [LED_COUNT-1:0]   led_push_pull_in,
    input  wire [LED_COUNT-1:0]   led_inactive_in,
    output reg  [LED_COUNT-1:0]   led_out,
    output reg  [LED_COUNT-1:0]   led_oe_out,
    output reg                    time_unit_clock_off_out,
    output reg                    stamp_unit2_clock_off_out,
    output reg                    stamp_unit1_clock_off_out,
    output reg                    stamp_unit0_clock_off_out,
    output reg                    fabric_clock_off_out,
    output reg  [2:0]             power_state_out,
    output reg                    pll_off_request_out,
    output reg                    power_event_irq_flag_out,
    output reg                    ready_irq_flag_out,
    output reg                    ready_out
);

    // =====================================================================
    // Sequencer states
    // =====================================================================
    localparam ST_RUN    = 2'h0;
    localparam ST_SLEEP  = 2'h1;
    localparam ST_WAKE   = 2'h2;
    localparam ST_SETTLE = 2'h3;

    reg [1:0]  state;
    reg [2:0]  target_power_state;
    reg        sleep_request;
    reg        auto_wake_enable;
    reg        indicator_outputs_off;
    reg        port_a_wake_event_flag;
    reg        port_b_wake_event_flag;
    reg        port_a_wake_event_enable;
    reg        port_b_wake_event_enable;
    reg        ready_q;
    reg [15:0] settle_count;
    reg        access_done;

    wire       time_off;
    wire       tsu2_off;
    wire       tsu1_off;
    wire       tsu0_off;
    wire       fabric_off;
    wire       timer_done;

    // =====================================================================
    // Bus decode
    // =====================================================================
    wire hit    = (avs_address_in == `PMC_CTRL_OFFSET);
    wire access = (avs_read_in | avs_write_in) & ~access_done;
    wire wr_hit = avs_write_in & ~access_done & hit;
    wire [31:0] wd = avs_writedata_in;
    wire be3 = avs_byteenable_in[3];
    wire be2 = avs_byteenable_in[2];
    wire be1 = avs_byteenable_in[1];

    wire mode_wr  = wr_hit & be3 & (wd[`PMC_MODE_HI:`PMC_MODE_LO] != target_power_state);
    wire sleep_wr = wr_hit & be3 & wd[`PMC_SLEEP_BIT];
    wire mode_ok  = mode_wr & ~sleep_wr;
    wire sleep_ok = sleep_wr & ~mode_wr & (state == ST_RUN);

    wire any_event = (port_a_event_in & port_a_wake_event_enable)
                   | (port_b_event_in & port_b_wake_event_enable);
    wire wake_now  = (state == ST_SLEEP)
                   & (manual_wake_in | (auto_wake_enable & any_event));

    // Mode 3 cannot wake automatically, the oscillator is stopped
    wire deep = (target_power_state == `PMC_MODE_DEEP);

    function [31:0] pack_reg;
        input dummy;
        begin
            pack_reg = `PMC_UNUSED_DATA;
            pack_reg[`PMC_MODE_HI:`PMC_MODE_LO] = target_power_state;
            pack_reg[`PMC_SLEEP_BIT]      = sleep_request;
            pack_reg[`PMC_WAKE_EN_BIT]    = auto_wake_enable;
            pack_reg[`PMC_LED_OFF_BIT]    = indicator_outputs_off;
            pack_reg[`PMC_TIME_OFF_BIT]   = time_off;
            pack_reg[`PMC_TSU2_OFF_BIT]   = tsu2_off;
            pack_reg[`PMC_TSU1_OFF_BIT]   = tsu1_off;
            pack_reg[`PMC_TSU0_OFF_BIT]   = tsu0_off;
            pack_reg[`PMC_FABRIC_OFF_BIT] = fabric_off;
            pack_reg[`PMC_STS_B_BIT]      = port_b_wake_event_flag;
            pack_reg[`PMC_STS_A_BIT]      = port_a_wake_event_flag;
            pack_reg[`PMC_EN_B_BIT]       = port_b_wake_event_enable;
            pack_reg[`PMC_EN_A_BIT]       = port_a_wake_event_enable;
            pack_reg[`PMC_READY_BIT]      = ready_q;
        end
    endfunction

    // =====================================================================
    // Avalon slave: one wait cycle, answer on the second edge
    // =====================================================================
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            access_done         <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
        end
        else
        begin
            access_done         <= access;
            avs_waitrequest_out <= ~access;
            // Reads answered in every power state, whole word always returned
            if (avs_read_in & ~access_done)
                avs_readdata_out <= hit ? pack_reg(1'b0) : `PMC_UNUSED_DATA;
        end
    end

    // =====================================================================
    // Writable fields
    // =====================================================================
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            target_power_state       <= `PMC_MODE_FULL;
            sleep_request            <= 1'b0;
            auto_wake_enable         <= 1'b0;
            indicator_outputs_off    <= 1'b0;
            port_a_wake_event_enable <= 1'b0;
            port_b_wake_event_enable <= 1'b0;
        end
        else
        begin
            if (state == ST_SETTLE && settle_count == 16'h0000 && pll_locked_in)
            begin
                target_power_state <= `PMC_MODE_FULL;
                sleep_request      <= 1'b0;
            end
            else
            begin
                if (mode_ok)
                    target_power_state <= wd[`PMC_MODE_HI:`PMC_MODE_LO];
                if (sleep_ok)
                    sleep_request <= 1'b1;
            end
            if (wr_hit & be3)
            begin
                auto_wake_enable      <= wd[`PMC_WAKE_EN_BIT];
                indicator_outputs_off <= wd[`PMC_LED_OFF_BIT];
            end
            if (wr_hit & be1)
            begin
                port_b_wake_event_enable <= wd[`PMC_EN_B_BIT];
                port_a_wake_event_enable <= wd[`PMC_EN_A_BIT];
            end
        end
    end

    // =====================================================================
    // Event status: set wins, clear needs the source gone
    // =====================================================================
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            port_a_wake_event_flag <= 1'b0;
            port_b_wake_event_flag <= 1'b0;
        end
        else
        begin
            if (port_a_event_in)
                port_a_wake_event_flag <= 1'b1;
            else if (wr_hit & be2 & wd[`PMC_STS_A_BIT])
                port_a_wake_event_flag <= 1'b0;
            if (port_b_event_in)
                port_b_wake_event_flag <= 1'b1;
            else if (wr_hit & be2 & wd[`PMC_STS_B_BIT])
                port_b_wake_event_flag <= 1'b0;
        end
    end

    // =====================================================================
    // Guarded clock disables
    // =====================================================================
    pmc_guard_bit u_time (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_hit & be3),
        .data_in(wd[`PMC_TIME_OFF_BIT]), .bit_out(time_off));
    pmc_guard_bit u_tsu2 (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_hit & be3),
        .data_in(wd[`PMC_TSU2_OFF_BIT]), .bit_out(tsu2_off));
    pmc_guard_bit u_tsu1 (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_hit & be2),
        .data_in(wd[`PMC_TSU1_OFF_BIT]), .bit_out(tsu1_off));
    pmc_guard_bit u_tsu0 (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_hit & be2),
        .data_in(wd[`PMC_TSU0_OFF_BIT]), .bit_out(tsu0_off));
    pmc_guard_bit u_fab  (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_hit & be2),
        .data_in(wd[`PMC_FABRIC_OFF_BIT]), .bit_out(fabric_off));

    // =====================================================================
    // Sleep and wake sequencer
    // =====================================================================
    pmc_wake_timer #(.WIDTH(16)) u_timer
    (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .start_in (wake_now),
        .load_in  (WAKE_CYCLES[15:0]),
        .busy_out (),
        .done_out (timer_done)
    );

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state        <= ST_RUN;
            settle_count <= 16'h0000;
            ready_q      <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (sleep_ok)
                    begin
                        state   <= ST_SLEEP;
                        ready_q <= 1'b0;
                    end
                    else
                        ready_q <= pll_locked_in;
                end
                ST_SLEEP:
                    if (wake_now && !(deep && !manual_wake_in))
                        state <= ST_WAKE;
                ST_WAKE:
                    if (timer_done)
                    begin
                        state        <= ST_SETTLE;
                        settle_count <= STABLE_CYCLES[15:0];
                    end
                ST_SETTLE:
                begin
                    if (!pll_locked_in)
                        settle_count <= STABLE_CYCLES[15:0];
                    else if (settle_count == 16'h0000)
                    begin
                        state   <= ST_RUN;
                        ready_q <= 1'b1;
                    end
                    else
                        settle_count <= settle_count - 16'h0001;
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    // =====================================================================
    // Registered outputs
    // =====================================================================
    integer i;
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            led_out                   <= {LED_COUNT{1'b0}};
            led_oe_out                <= {LED_COUNT{1'b0}};
            time_unit_clock_off_out   <= 1'b0;
            stamp_unit2_clock_off_out <= 1'b0;
            stamp_unit1_clock_off_out <= 1'b0;
            stamp_unit0_clock_off_out <= 1'b0;
            fabric_clock_off_out      <= 1'b0;
            power_state_out           <= `PMC_MODE_FULL;
            pll_off_request_out       <= 1'b0;
            power_event_irq_flag_out  <= 1'b0;
            ready_irq_flag_out        <= 1'b0;
            ready_out                 <= 1'b0;
        end
        else
        begin
            for (i = 0; i < LED_COUNT; i = i + 1)
            begin
                if (indicator_outputs_off)
                begin
                    led_out[i]    <= led_inactive_in[i];
                    led_oe_out[i] <= led_push_pull_in[i];
                end
                else
                begin
                    led_out[i]    <= led_value_in[i];
                    led_oe_out[i] <= 1'b1;
                end
            end
            time_unit_clock_off_out   <= time_off;
            stamp_unit2_clock_off_out <= tsu2_off;
            stamp_unit1_clock_off_out <= tsu1_off;
            stamp_unit0_clock_off_out <= tsu0_off;
            fabric_clock_off_out      <= fabric_off;
            power_state_out           <= (state == ST_SLEEP) ? target_power_state
                                                             : `PMC_MODE_FULL;
            pll_off_request_out       <= (state == ST_SLEEP) &&
                                         (target_power_state == `PMC_MODE_MEDIUM || deep);
            power_event_irq_flag_out  <= any_event;
            ready_irq_flag_out        <= ready_q & ~ready_out;
            ready_out                 <= ready_q;
        end
    end

endmodule // pmc_power_ctrl

// file: hdl/pmc_wake_timer.v
// Down counter that times the return to full power

module pmc_wake_timer
#(
    parameter WIDTH = 16
)
(
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             start_in,
    input  wire [WIDTH-1:0] load_in,
    output reg              busy_out,
    output reg              done_out
);

    reg [WIDTH-1:0] count;

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            count    <= {WIDTH{1'b0}};
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (start_in)
            begin
                count    <= load_in;
                busy_out <= 1'b1;
            end
            else if (busy_out)
            begin
                if (count == {WIDTH{1'b0}})
                begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
                else
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // pmc_wake_timer

// file: verification/pmc_power_ctrl_monitor.sv
// Port-level assertions for the power control register
module pmc_power_ctrl_monitor
(
    input wire        clk_in,
    input wire        rst_in,
    input wire [11:0] avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        port_a_event_in,
    input wire        port_b_event_in,
    input wire        time_unit_clock_off_out,
    input wire        fabric_clock_off_out,
    input wire [2:0]  power_state_out,
    input wire        pll_off_request_out,
    input wire        power_event_irq_flag_out,
    input wire        ready_irq_flag_out,
    input wire        ready_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_wait_one_cycle: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_reserved_read_zero: assert property ((avs_read_in && !avs_waitrequest_out
        && avs_address_in == 12'h084) |-> (avs_readdata_out & 32'h002c3ffe) == 32'h0)
        else $error("reserved bits read nonzero");
    a_ready_edge_flag: assert property ($rose(ready_out) |-> ##[0:1] ready_irq_flag_out)
        else $error("ready rise without ready flag");
    a_ready_flag_pulse: assert property (ready_irq_flag_out |=> !ready_irq_flag_out)
        else $error("ready flag longer than one cycle");
    a_sleep_not_ready: assert property (power_state_out != 3'h0 |=> !ready_out)
        else $error("ready high in a sleep state");
    a_reset_all_idle: assert property ($fell(rst_in) |-> !fabric_clock_off_out
        && !time_unit_clock_off_out && power_state_out == 3'h0)
        else $error("state not cleared by reset");
    a_pll_off_modes: assert property (pll_off_request_out |-> power_state_out inside {3'h2, 3'h3})
        else $error("pll off request in wrong state");
    a_state_code_legal: assert property (power_state_out <= 3'h3)
        else $error("reserved power state entered");
    a_event_flag_cause: assert property (power_event_irq_flag_out
        |-> $past(port_a_event_in) || $past(port_b_event_in))
        else $error("power event flag without port event");
    a_gate_after_write: assert property ($rose(fabric_clock_off_out)
        |-> $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("fabric clock gated without a write");
endmodule // pmc_power_ctrl_monitor

bind pmc_power_ctrl pmc_power_ctrl_monitor u_mon
(
    .clk_in                  (clk_in),
    .rst_in                  (rst_in),
    .avs_address_in          (avs_address_in),
    .avs_read_in             (avs_read_in),
    .avs_write_in            (avs_write_in),
    .avs_readdata_out        (avs_readdata_out),
    .avs_waitrequest_out     (avs_waitrequest_out),
    .port_a_event_in         (port_a_event_in),
    .port_b_event_in         (port_b_event_in),
    .time_unit_clock_off_out (time_unit_clock_off_out),
    .fabric_clock_off_out    (fabric_clock_off_out),
    .power_state_out         (power_state_out),
    .pll_off_request_out     (pll_off_request_out),
    .power_event_irq_flag_out(power_event_irq_flag_out),
    .ready_irq_flag_out      (ready_irq_flag_out),
    .ready_out               (ready_out)
);

// file: verification/pmc_xcvr_model.sv
// Behavioural transceiver and PLL partner for the power control register
module pmc_xcvr_model
(
    input  wire logic clk_in,
    input  wire logic pll_off_in,
    input  wire logic evt_a_in,
    input  wire logic evt_b_in,
    output wire logic port_a_event_out,
    output wire logic port_b_event_out,
    output wire logic pll_locked_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       evt_a    = 1'b0;
    logic       evt_b    = 1'b0;
    logic [1:0] lock_cnt = 2'h3;

    // Events follow their testbench inputs one clock later and stay up while those are held
    always @(posedge clk_in)
    begin
        evt_a <= evt_a_in;
        evt_b <= evt_b_in;
        if (pll_off_in)
            lock_cnt <= 2'h0;
        else if (lock_cnt != 2'h3)
            lock_cnt <= lock_cnt + 2'h1;
    end

    assign port_a_event_out = evt_a;
    assign port_b_event_out = evt_b;
    assign pll_locked_out   = (lock_cnt == 2'h3);
endmodule // pmc_xcvr_model

// file: verification/tb_power_mgmt_control_reg.sv
// Self-checking testbench for the power control register
module tb_power_mgmt_control_reg;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [11:0] addr   = 12'h0;
    logic        rd     = 1'b0;
    logic        wr     = 1'b0;
    logic [31:0] wdata  = 32'h0;
    logic [3:0]  be     = 4'hf;
    logic        evt_a  = 1'b0;
    logic        evt_b  = 1'b0;
    logic        wake   = 1'b0;
    logic [2:0]  led_v  = 3'h3;
    logic [2:0]  led_pp = 3'h5;
    logic [2:0]  led_in = 3'h4;
    wire  [31:0] rdata;
    wire         wait_r, ev_a, ev_b, pll, pll_off, pev, rdy;
    wire         t_off, s2, s1, s0, f_off;
    wire  [2:0]  led_o, led_oe, pstate;
    int          num_errors = 0;
    int          samples_checked = 0;

    always #20 clk_in = ~clk_in;

    // Short wake and settle counts keep the sleep loop quick
    pmc_power_ctrl #(.WAKE_CYCLES(8), .STABLE_CYCLES(2), .LED_COUNT(3)) dut
    (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .port_a_event_in(ev_a),
        .port_b_event_in(ev_b), .manual_wake_in(wake), .pll_locked_in(pll),
        .led_value_in(led_v), .led_push_pull_in(led_pp), .led_inactive_in(led_in),
        .led_out(led_o), .led_oe_out(led_oe), .time_unit_clock_off_out(t_off),
        .stamp_unit2_clock_off_out(s2), .stamp_unit1_clock_off_out(s1),
        .stamp_unit0_clock_off_out(s0), .fabric_clock_off_out(f_off),
        .power_state_out(pstate), .pll_off_request_out(pll_off),
        .power_event_irq_flag_out(pev), .ready_irq_flag_out(), .ready_out(rdy)
    );

    pmc_xcvr_model u_xcvr
    (
        .clk_in(clk_in), .pll_off_in(pll_off), .evt_a_in(evt_a), .evt_b_in(evt_b),
        .port_a_event_out(ev_a), .port_b_event_out(ev_b), .pll_locked_out(pll)
    );

    // ==========================================
    // Bus master and compare helpers
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        @(posedge clk_in);
        while (wait_r !== 1'b0 && n < 50)
        begin
            @(posedge clk_in);
            n++;
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
            num_errors++;
    endtask

    task automatic wreg(input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, 12'h084, d, 4'hf, r);
    endtask

    task automatic rreg(input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, 12'h084, 32'h0, 4'hf, r);
        chk(e, r);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 300)
        begin
            @(posedge clk_in);
            n++;
        end
        chk(32'h1, {31'h0, rdy});
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_and_fields();
        logic [31:0] r;
        wait_ready();
        rreg(32'h00000001);
        chk(32'h0, {27'h0, t_off, s2, s1, s0, f_off});
        wreg(32'h0c2cfffe);
        rreg(32'h0c00c001);
        chk(32'h5, {29'h0, led_oe});
        chk(32'h4, {29'h0, led_o & led_oe});
        bus(1'b0, 12'h084, 32'h0, 4'h1, r);
        chk(32'h0c00c001, r);
        bus(1'b1, 12'h088, 32'hffffffff, 4'hf, r);
        bus(1'b0, 12'h088, 32'h0, 4'hf, r);
        chk(32'h0, r);
        wreg(32'h0);
        rreg(32'h00000001);
    endtask

    task automatic t_clock_guard();
        wreg(32'h00100000);
        rreg(32'h00000001);
        wreg(32'h00100000);
        rreg(32'h00100001);
        wreg(32'h02100000);
        wreg(32'h00100000);
        wreg(32'h02100000);
        chk(32'h0, {31'h0, t_off});
        wreg(32'h03d00000);
        rreg(32'h02100001);
        wreg(32'h03d00000);
        rreg(32'h03d00001);
        chk(32'h1f, {27'h0, t_off, s2, s1, s0, f_off});
        wreg(32'h0);
        @(posedge clk_in);
        chk(32'h0, {27'h0, t_off, s2, s1, s0, f_off});
    endtask

    task automatic t_sleep_modes();
        wreg(32'h30000000);
        rreg(32'h00000001);
        for (int m = 1; m < 4; m++)
        begin
            wreg({m[2:0], 29'h0});
            rreg({m[2:0], 29'h1});
            wreg({m[2:0], 1'b1, 28'h0});
            repeat (2) @(posedge clk_in);
            chk({29'h0, m[2:0]}, {29'h0, pstate});
            chk({31'h0, m > 1}, {31'h0, pll_off});
            chk(32'h0, {31'h0, rdy});
            rreg({m[2:0], 1'b1, 28'h0});
            wake <= 1'b1;
            @(posedge clk_in);
            wake <= 1'b0;
            wait_ready();
            rreg(32'h00000001);
        end
    endtask

    task automatic t_events();
        logic [31:0] r;
        wreg(32'h2800c000);
        wreg(32'h3800c000);
        repeat (2) @(posedge clk_in);
        chk(32'h0, {31'h0, rdy});
        evt_a <= 1'b1;
        wait_ready();
        chk(32'h1, {31'h0, pev});
        rreg(32'h0801c001);
        wreg(32'h0801c000);
        rreg(32'h0801c001);
        evt_a <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(32'h0, {31'h0, pev});
        wreg(32'h0801c000);
        rreg(32'h0800c001);
        evt_b <= 1'b1;
        repeat (3) @(posedge clk_in);
        bus(1'b0, 12'h084, 32'h0, 4'h4, r);
        chk(32'h0802c001, r);
        wreg(32'h0);
        repeat (3) @(posedge clk_in);
        chk(32'h0, {31'h0, pev});
        evt_b <= 1'b0;
        repeat (3) @(posedge clk_in);
        wreg(32'h00020000);
        rreg(32'h00000001);
        // Deepest state ignores automatic wake, only a manual wake leaves it
        wreg(32'h6800c000);
        wreg(32'h7800c000);
        evt_a <= 1'b1;
        repeat (20) @(posedge clk_in);
        chk(32'h3, {29'h0, pstate});
        evt_a <= 1'b0;
        wake <= 1'b1;
        @(posedge clk_in);
        wake <= 1'b0;
        wait_ready();
        wreg(32'h00010000);
        rreg(32'h00000001);
    endtask

    task automatic t_mid_reset();
        wreg(32'h0c100000);
        wreg(32'h0c100000);
        rreg(32'h0c100001);
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(32'h0, {27'h0, t_off, s2, s1, s0, f_off});
        wait_ready();
        rreg(32'h00000001);
    endtask

    // ==========================================
    // Run control
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #800us;
        num_errors++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset_and_fields();
        t_clock_guard();
        t_sleep_modes();
        t_events();
        t_mid_reset();
        conclude();
    end
endmodule // tb_power_mgmt_control_reg
